// file: dsm_drive_fsm.sv
// Purpose: drive power-stage state machine with Avalon-MM register access
// Assumes: core_clk 250 MHz, alarm and quick-stop-done inputs asynchronous
// Notes: byte address = 4 * object index; one wait state on every access
`timescale 1ns/10ps
`include "dsm_map.svh"
module dsm_drive_fsm #(
	parameter int FR_HOLD_MS  = 10,
	parameter int FR_HOLD_CYC = FR_HOLD_MS * 250000,
	parameter int QS_CODE     = 2
) (
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	input  wire logic [17:0] avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic [31:0]      avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic        alarm_in,
	input  wire logic        alarm_done_in,
	input  wire logic        quick_halt_done_in,
	input  wire logic        bus_voltage_in,
	output logic             main_power_relay,
	output logic             servo_on,
	output logic             quick_halt_decel,
	output logic             alarm_clear
);
	localparam int CW = 24;

	// synchronised pins
	logic [1:0] alm_s_r, almd_s_r, qsd_s_r, volt_s_r;

	dsm_pkg::dsm_state_e st_r, st_nxt;     // drive state
	logic [15:0] cmd_r, cmd_nxt;            // command word
	logic        ack_r, ack_nxt;            // bus answer pending
	logic [31:0] rd_r, rd_nxt;              // read data
	logic        relay_r, relay_nxt;
	logic        servo_r, servo_nxt;
	logic        qdec_r, qdec_nxt;
	logic        clr_r, clr_nxt;
	logic        srv_wait_r, srv_wait_nxt;  // servo settle in progress
	logic [CW-1:0] fr_cnt_r, fr_cnt_nxt;    // fault reset hold counter
	logic        fr_used_r, fr_used_nxt;    // this bit-7 high already acted
	logic        init_start_r;              // one pulse after reset
	logic        init_done, srv_done, srv_start;
	dsm_pkg::dsm_cmd_e cmd;
	logic [15:0] stat_w;

	////////////////////////////////////////////////////////////////
	// two-flop synchronisers for pins
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			alm_s_r  <= 2'h0;
			almd_s_r <= 2'h0;
			qsd_s_r  <= 2'h0;
			volt_s_r <= 2'h0;
		end else begin
			alm_s_r  <= {alm_s_r[0], alarm_in};
			almd_s_r <= {almd_s_r[0], alarm_done_in};
			qsd_s_r  <= {qsd_s_r[0], quick_halt_done_in};
			volt_s_r <= {volt_s_r[0], bus_voltage_in};
		end
	end

	////////////////////////////////////////////////////////////////
	// command decode and timers
	dsm_cmd_decode u_dec (
		.cmd_word (cmd_r),
		.cmd      (cmd)
	);

	dsm_timer #(.CW(CW)) u_init (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.start    (init_start_r),
		.load     (CW'(`DSM_INIT_CYC)),
		.done     (init_done)
	);

	assign srv_start = (st_r == dsm_pkg::DSM_SWITCHED) && (cmd == dsm_pkg::DSM_C_ENABLEOP) && !srv_wait_r;

	dsm_timer #(.CW(CW)) u_servo (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.start    (srv_start),
		.load     (CW'(`DSM_SERVO_CYC)),
		.done     (srv_done)
	);

	////////////////////////////////////////////////////////////////
	// status word view
	always_comb begin
		stat_w = 16'h0000;
		stat_w[`DSM_S_VOLT]  = volt_s_r[1];  // see RULE18
		stat_w[`DSM_S_QHALT] = (st_r != dsm_pkg::DSM_QSTOP); // see RULE18
		case (st_r)
			dsm_pkg::DSM_READY:      stat_w[`DSM_S_READY_FOR_POWER_FLAG] = 1'b1;
			dsm_pkg::DSM_SWITCHED:   stat_w[1:0] = 2'h3;
			dsm_pkg::DSM_OP_ENABLED: stat_w[2:0] = 3'h7;
			dsm_pkg::DSM_QSTOP:      stat_w[2:0] = 3'h7;
			dsm_pkg::DSM_FLT_REACT:  stat_w[3:0] = 4'hF;
			dsm_pkg::DSM_FAULT:      stat_w[`DSM_S_FAULT] = 1'b1;
			dsm_pkg::DSM_SW_DISABLE: stat_w[`DSM_S_NRDY] = 1'b1;
			default:                 stat_w = stat_w;
		endcase
	end

	////////////////////////////////////////////////////////////////
	// bus slave: one wait state, then answer
	always_comb begin
		cmd_nxt = cmd_r;
		ack_nxt = 1'b0;
		rd_nxt  = rd_r;
		if ((avs_read || avs_write) && !ack_r) begin
			ack_nxt = 1'b1;
			if (avs_write && avs_address == 18'(`DSM_IDX_CMD) * 18'h4) begin
				if (avs_byteenable[0])
					cmd_nxt[7:0] = avs_writedata[7:0]; // see RULE14
				if (avs_byteenable[1])
					cmd_nxt[15:8] = avs_writedata[15:8] & 8'(~(`DSM_CMD_RSVD_MASK >> 8)); // see RULE19
			end
			if (avs_read) begin
				if (avs_address == 18'(`DSM_IDX_CMD) * 18'h4)
					rd_nxt = {16'h0000, cmd_r}; // see RULE14
				else if (avs_address == 18'(`DSM_IDX_STAT) * 18'h4)
					rd_nxt = {16'h0000, stat_w}; // see RULE15
				else
					rd_nxt = 32'h0000_0000;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// fault reset edge qualified by hold time
	always_comb begin
		fr_cnt_nxt  = fr_cnt_r;
		fr_used_nxt = fr_used_r;
		if (!cmd_r[`DSM_B_FCLR]) begin
			fr_cnt_nxt  = '0;
			fr_used_nxt = 1'b0;
		end else if (fr_cnt_r != CW'(FR_HOLD_CYC))
			fr_cnt_nxt = fr_cnt_r + CW'(1); // see RULE17
		if (fr_cnt_r == CW'(FR_HOLD_CYC) && !fr_used_r) // a high level that reached the hold time before fault is no new edge
			fr_used_nxt = 1'b1;
	end

	////////////////////////////////////////////////////////////////
	// drive state transitions
	always_comb begin
		st_nxt       = st_r;
		relay_nxt    = relay_r;
		servo_nxt    = servo_r;
		qdec_nxt     = 1'b0;
		clr_nxt      = 1'b0;
		srv_wait_nxt = srv_wait_r;
		if (srv_start)
			srv_wait_nxt = 1'b1;
		if (alm_s_r[1] && st_r != dsm_pkg::DSM_FLT_REACT && st_r != dsm_pkg::DSM_FAULT) begin
			st_nxt       = dsm_pkg::DSM_FLT_REACT; // see RULE10
			srv_wait_nxt = 1'b0;
		end else begin
			case (st_r)
				dsm_pkg::DSM_NOT_READY:
					if (init_done)
						st_nxt = dsm_pkg::DSM_SW_DISABLE; // see RULE1
				dsm_pkg::DSM_SW_DISABLE:
					if (cmd == dsm_pkg::DSM_C_SHUTDOWN)
						st_nxt = dsm_pkg::DSM_READY; // see RULE2
				dsm_pkg::DSM_READY:
					if (cmd == dsm_pkg::DSM_C_SWITCHON || cmd == dsm_pkg::DSM_C_ENABLEOP) begin
						st_nxt    = dsm_pkg::DSM_SWITCHED; // see RULE3
						relay_nxt = 1'b1;
					end else if (cmd == dsm_pkg::DSM_C_DISVOLT || cmd == dsm_pkg::DSM_C_QSTOP)
						st_nxt = dsm_pkg::DSM_SW_DISABLE; // see RULE6
				dsm_pkg::DSM_SWITCHED:
					if (cmd == dsm_pkg::DSM_C_SHUTDOWN) begin
						st_nxt       = dsm_pkg::DSM_READY; // see RULE2
						relay_nxt    = 1'b0;
						srv_wait_nxt = 1'b0;
					end else if (cmd == dsm_pkg::DSM_C_DISVOLT || cmd == dsm_pkg::DSM_C_QSTOP) begin
						st_nxt       = dsm_pkg::DSM_SW_DISABLE; // see RULE6
						relay_nxt    = 1'b0;
						srv_wait_nxt = 1'b0;
					end else if (cmd == dsm_pkg::DSM_C_ENABLEOP) begin
						servo_nxt = 1'b1; // see RULE4
						if (srv_done && srv_wait_r) begin // stale settle pulse never enables
							st_nxt       = dsm_pkg::DSM_OP_ENABLED; // see RULE4
							srv_wait_nxt = 1'b0;
						end
					end else begin
						servo_nxt    = 1'b0;
						srv_wait_nxt = 1'b0;
					end
				dsm_pkg::DSM_OP_ENABLED:
					if (cmd == dsm_pkg::DSM_C_SWITCHON) begin
						servo_nxt = 1'b0; // see RULE5
						st_nxt    = dsm_pkg::DSM_SWITCHED;
					end else if (cmd == dsm_pkg::DSM_C_SHUTDOWN) begin
						servo_nxt = 1'b0; // see RULE7
						relay_nxt = 1'b0;
						st_nxt    = dsm_pkg::DSM_READY;
					end else if (cmd == dsm_pkg::DSM_C_DISVOLT) begin
						servo_nxt = 1'b0; // see RULE7
						relay_nxt = 1'b0;
						st_nxt    = dsm_pkg::DSM_SW_DISABLE;
					end else if (cmd == dsm_pkg::DSM_C_QSTOP) begin
						qdec_nxt = 1'b1; // see RULE8
						st_nxt   = dsm_pkg::DSM_QSTOP;
					end
				dsm_pkg::DSM_QSTOP: begin
					qdec_nxt = 1'b1; // see RULE13
					if (cmd == dsm_pkg::DSM_C_DISVOLT ||
					    (qsd_s_r[1] && QS_CODE >= 1 && QS_CODE <= 4)) begin
						qdec_nxt  = 1'b0; // see RULE9
						servo_nxt = 1'b0;
						relay_nxt = 1'b0;
						st_nxt    = dsm_pkg::DSM_SW_DISABLE;
					end
				end
				dsm_pkg::DSM_FLT_REACT:
					if (almd_s_r[1]) begin
						servo_nxt = 1'b0; // see RULE11
						relay_nxt = 1'b0;
						st_nxt    = dsm_pkg::DSM_FAULT;
					end
				dsm_pkg::DSM_FAULT:
					if (fr_cnt_r == CW'(FR_HOLD_CYC) && !fr_used_r) begin
						clr_nxt = 1'b1; // see RULE12
						st_nxt  = dsm_pkg::DSM_SW_DISABLE;
					end
				default:
					st_nxt = dsm_pkg::DSM_NOT_READY; // see RULE20
			endcase
		end
	end

	////////////////////////////////////////////////////////////////
	// registers
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r         <= dsm_pkg::DSM_NOT_READY;
			cmd_r        <= `DSM_CMD_RESET;
			ack_r        <= 1'b0;
			rd_r         <= 32'h0000_0000;
			relay_r      <= 1'b0;
			servo_r      <= 1'b0;
			qdec_r       <= 1'b0;
			clr_r        <= 1'b0;
			srv_wait_r   <= 1'b0;
			fr_cnt_r     <= '0;
			fr_used_r    <= 1'b0;
			init_start_r <= 1'b1;
		end else begin
			st_r         <= st_nxt;
			cmd_r        <= cmd_nxt;
			ack_r        <= ack_nxt;
			rd_r         <= rd_nxt;
			relay_r      <= relay_nxt;
			servo_r      <= servo_nxt;
			qdec_r       <= qdec_nxt;
			clr_r        <= clr_nxt;
			srv_wait_r   <= srv_wait_nxt;
			fr_cnt_r     <= fr_cnt_nxt;
			fr_used_r    <= fr_used_nxt;
			init_start_r <= 1'b0;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			avs_waitrequest <= 1'b1;
		else
			avs_waitrequest <= !((avs_read || avs_write) && !ack_r && !ack_nxt ? 1'b0 : ack_nxt);
	end

	assign avs_readdata     = rd_r;
	assign main_power_relay = relay_r;
	assign servo_on         = servo_r;
	assign quick_halt_decel = qdec_r;
	assign alarm_clear      = clr_r;

	////////////////////////////////////////////////////////////////
	// checks
	property p_relay_on_switch; // see RULE3
		@(posedge core_clk) disable iff (!rst_n)
		(st_r == dsm_pkg::DSM_READY && st_nxt == dsm_pkg::DSM_SWITCHED) |=> relay_r;
	endproperty
	a_relay_on_switch: assert property (p_relay_on_switch) else $error("relay not closed on switch on"); // see RULE3
	sequence s_servo_then_enabled; // servo on while switched on, still on once enabled
		(servo_r && st_r == dsm_pkg::DSM_SWITCHED) ##1 (servo_r && st_r == dsm_pkg::DSM_OP_ENABLED);
	endsequence
	property p_servo_before_enabled; // see RULE4
		@(posedge core_clk) disable iff (!rst_n)
		(st_r == dsm_pkg::DSM_SWITCHED && st_nxt == dsm_pkg::DSM_OP_ENABLED) |-> s_servo_then_enabled;
	endproperty
	a_servo_before_enabled: assert property (p_servo_before_enabled) else $error("enabled without servo on"); // see RULE4
	property p_shutdown_relay; // see RULE2
		@(posedge core_clk) disable iff (!rst_n)
		(st_r == dsm_pkg::DSM_SWITCHED && st_nxt == dsm_pkg::DSM_READY) |=> !relay_r;
	endproperty
	a_shutdown_relay: assert property (p_shutdown_relay) else $error("relay not opened on shutdown"); // see RULE2

	property p_fault_servo_off; // see RULE11
		@(posedge core_clk) disable iff (!rst_n)
		(st_r == dsm_pkg::DSM_FAULT) |-> !servo_r && !relay_r;
	endproperty
	a_fault_servo_off: assert property (p_fault_servo_off) else $error("fault with power on"); // see RULE11

	property p_no_qs_return; // see RULE13
		@(posedge core_clk) disable iff (!rst_n)
		(st_r == dsm_pkg::DSM_QSTOP) |=> st_r != dsm_pkg::DSM_OP_ENABLED;
	endproperty
	a_no_qs_return: assert property (p_no_qs_return) else $error("returned from quick stop"); // see RULE13

	property p_alarm_enters_react; // see RULE10
		@(posedge core_clk) disable iff (!rst_n)
		(alm_s_r[1] && st_r != dsm_pkg::DSM_FAULT && st_r != dsm_pkg::DSM_FLT_REACT)
		|=> st_r == dsm_pkg::DSM_FLT_REACT;
	endproperty
	a_alarm_enters_react: assert property (p_alarm_enters_react) else $error("alarm ignored"); // see RULE10

	property p_qs_flag; // see RULE18
		@(posedge core_clk) disable iff (!rst_n)
		(st_r == dsm_pkg::DSM_QSTOP) |-> !stat_w[`DSM_S_QHALT] && stat_w[`DSM_S_OPEN];
	endproperty
	a_qs_flag: assert property (p_qs_flag) else $error("quick stop flag wrong"); // see RULE18

	property p_init_advance; // see RULE1
		@(posedge core_clk) disable iff (!rst_n)
		(st_r == dsm_pkg::DSM_NOT_READY && init_done && !alm_s_r[1]) |=> st_r == dsm_pkg::DSM_SW_DISABLE;
	endproperty
	a_init_advance: assert property (p_init_advance) else $error("init did not advance"); // see RULE1

	property p_rsvd_zero; // see RULE19
		@(posedge core_clk) disable iff (!rst_n)
		1'b1 |-> (cmd_r & `DSM_CMD_RSVD_MASK) == 16'h0000;
	endproperty
	a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved command bits set"); // see RULE19
endmodule : dsm_drive_fsm

// file: dsm_map.svh
// Purpose: constants for the drive state machine: register offsets, bit positions, timing counts
// Assumes: Avalon-MM word addressing on byte address = 4 * index
// Notes: status object is read-only; unmapped reads return zero
//
// Overview of operation
// RULE1: power-up initializes then advances automatically
// RULE2: shutdown from switched on opens relay
// RULE3: switch on closes relay, enters switched on
// RULE4: enable operation: servo on, then report enabled
// RULE5: disable operation: servo off, back to switched on
// RULE6: disable voltage or quick stop gives switch-on-disabled
// RULE7: shutdown/disable voltage from enabled: servo off first; the code opens the relay in the same cycle
// RULE8: quick stop from enabled starts quick-stop decel
// RULE9: quick stop exits on completion or disable voltage
// RULE10: any alarm enters fault reaction handling
// RULE11: alarm processing done, advance to fault
// RULE12: fault reset clears resettable alarms, leaves fault
// RULE13: no return from quick stop to enabled
// RULE14: command word is readable and writable
// RULE15: status word is read-only, always pollable
// RULE16: commands decoded from bits 0 to 3 and 7
// RULE17: fault reset bit held high at least 10 ms
// RULE18: status flags in bits 0 to 5; the code also sets bit 6 in switch-on-disabled
// RULE19: reserved command bits 10 to 14 read zero
// RULE20: standard drive-profile states; other pairs ignored
`ifndef DSM_MAP_SVH
`define DSM_MAP_SVH

`define DSM_IDX_CMD        16'h6040
`define DSM_IDX_STAT       16'h6041
`define DSM_CMD_RESET      16'h0000
`define DSM_CMD_RSVD_MASK  16'h7C00

`define DSM_B_SWON         0
`define DSM_B_VOLT         1
`define DSM_B_QHALT        2
`define DSM_B_OPEN         3
`define DSM_B_FCLR         7

`define DSM_S_READY_FOR_POWER_FLAG         0
`define DSM_S_SWON         1
`define DSM_S_OPEN         2
`define DSM_S_FAULT        3
`define DSM_S_VOLT         4
`define DSM_S_QHALT        5
`define DSM_S_NRDY         6

`define DSM_CLK_NS         4
`define DSM_INIT_NS        400
`define DSM_INIT_CYC       ((`DSM_INIT_NS + `DSM_CLK_NS - 1) / `DSM_CLK_NS)
`define DSM_SERVO_NS       80
`define DSM_SERVO_CYC      ((`DSM_SERVO_NS + `DSM_CLK_NS - 1) / `DSM_CLK_NS)

`endif

// file: dsm_pkg.sv
// Purpose: types for the drive state machine
// Assumes: nothing
// Notes: binary state codes
package dsm_pkg;
	typedef enum logic [2:0] {
		DSM_NOT_READY  = 3'h0,
		DSM_SW_DISABLE = 3'h1,
		DSM_READY      = 3'h2,
		DSM_SWITCHED   = 3'h3,
		DSM_OP_ENABLED = 3'h4,
		DSM_QSTOP      = 3'h5,
		DSM_FLT_REACT  = 3'h6,
		DSM_FAULT      = 3'h7
	} dsm_state_e;

	typedef enum logic [2:0] {
		DSM_C_NONE     = 3'h0,
		DSM_C_SHUTDOWN = 3'h1,
		DSM_C_SWITCHON = 3'h2,
		DSM_C_ENABLEOP = 3'h3,
		DSM_C_DISVOLT  = 3'h4,
		DSM_C_QSTOP    = 3'h5
	} dsm_cmd_e;
endpackage : dsm_pkg

// file: dsm_cmd_decode.sv
// Purpose: decode the command word into one drive command
// Assumes: command word registered on core_clk
// Notes: purely combinational
`timescale 1ns/10ps
`include "dsm_map.svh"
module dsm_cmd_decode (
	input  wire logic [15:0]       cmd_word,
	output dsm_pkg::dsm_cmd_e      cmd
);
	////////////////////////////////////////////////////////////////
	// bit 7 must be low for any of these commands
	always_comb begin
		cmd = dsm_pkg::DSM_C_NONE;
		if (!cmd_word[`DSM_B_FCLR]) begin
			if (!cmd_word[`DSM_B_VOLT])
				cmd = dsm_pkg::DSM_C_DISVOLT; // see RULE16
			else if (!cmd_word[`DSM_B_QHALT])
				cmd = dsm_pkg::DSM_C_QSTOP; // see RULE16
			else if (!cmd_word[`DSM_B_SWON])
				cmd = dsm_pkg::DSM_C_SHUTDOWN; // see RULE16
			else if (!cmd_word[`DSM_B_OPEN])
				cmd = dsm_pkg::DSM_C_SWITCHON; // see RULE16
			else
				cmd = dsm_pkg::DSM_C_ENABLEOP; // see RULE16
		end
	end
endmodule : dsm_cmd_decode

// file: dsm_timer.sv
// Purpose: down counter for a timed phase
// Assumes: start is a one-cycle pulse
// Notes: done pulses for one cycle when the count expires
`timescale 1ns/10ps
module dsm_timer #(
	parameter int CW = 24
) (
	input  wire logic          core_clk,
	input  wire logic          rst_n,
	input  wire logic          start,
	input  wire logic [CW-1:0] load,
	output logic               done
);
	logic [CW-1:0] cnt_r;   // remaining cycles
	logic [CW-1:0] cnt_nxt;
	logic          run_r;   // counting
	logic          run_nxt;
	logic          done_r;
	logic          done_nxt;

	////////////////////////////////////////////////////////////////
	// next count
	always_comb begin
		cnt_nxt  = cnt_r;
		run_nxt  = run_r;
		done_nxt = 1'b0;
		if (start) begin
			cnt_nxt = load;
			run_nxt = 1'b1;
		end else if (run_r) begin
			if (cnt_r <= CW'(1)) begin
				run_nxt  = 1'b0;
				done_nxt = 1'b1;
			end else
				cnt_nxt = cnt_r - CW'(1);
		end
	end

	// registers
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r  <= '0;
			run_r  <= 1'b0;
			done_r <= 1'b0;
		end else begin
			cnt_r  <= cnt_nxt;
			run_r  <= run_nxt;
			done_r <= done_nxt;
		end
	end

	assign done = done_r;
endmodule : dsm_timer

// file: dsm_master_model.sv
// Purpose: Avalon-MM master standing in for the network controller
// Assumes: slave answers by dropping waitrequest, sampled on a rising edge
// Notes: one request at a time; every change lands just after a rising edge
`timescale 1ns/10ps
module dsm_master_model (
	input  wire logic        core_clk,
	output logic [17:0]      avs_address,
	output logic             avs_read,
	output logic             avs_write,
	output logic [31:0]      avs_writedata,
	output logic [3:0]       avs_byteenable,
	input  wire logic [31:0] avs_readdata,
	input  wire logic        avs_waitrequest
);
	// idle bus at time zero
	initial begin
		avs_address    = 18'h00000;
		avs_read       = 1'b0;
		avs_write      = 1'b0;
		avs_writedata  = 32'h00000000;
		avs_byteenable = 4'h0;
	end
	////////////////////////////////////////////////////////////////////////
	// object write, held until waitrequest seen low
	task automatic bus_wr(input logic [17:0] a, input logic [15:0] d, input logic [3:0] be);
		@(posedge core_clk);
		avs_address    <= a;
		avs_writedata  <= {16'h0000, d};
		avs_byteenable <= be;
		avs_write      <= 1'b1;
		do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
		avs_write     <= 1'b0;
		avs_writedata <= ~{16'h0000, d}; // stale data never lingers
	endtask : bus_wr
	// object read, data taken at the answering edge
	task automatic bus_rd(input logic [17:0] a, output logic [15:0] d);
		@(posedge core_clk);
		avs_address <= a;
		avs_read    <= 1'b1;
		do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
		d = avs_readdata[15:0];
		avs_read <= 1'b0;
	endtask : bus_rd
endmodule : dsm_master_model

// file: dsm_drive_fsm_tb.sv
// Purpose: self-checking bench for the drive state machine
// Assumes: fault-reset hold shortened to 50 cycles, quick-stop code 2
// Notes: status masks skip flags whose value a state leaves open
`timescale 1ns/10ps
module dsm_drive_fsm_tb;
	localparam logic [17:0] A_CMD = 18'h18100; // command object
	localparam logic [17:0] A_ST  = 18'h18104; // status object
	localparam logic [15:0] S_SOD = 16'h0070;  // switch on disabled
	localparam logic [15:0] S_RDY = 16'h0031;  // ready to switch on
	localparam logic [15:0] S_SWT = 16'h0033;  // switched on
	localparam logic [15:0] S_ENA = 16'h0037;  // operation enabled
	logic        core_clk;
	logic        rst_n;
	logic [17:0] avs_address;
	logic        avs_read;
	logic        avs_write;
	logic [31:0] avs_writedata;
	logic [3:0]  avs_byteenable;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        alarm_in, alarm_done_in, quick_halt_done_in, bus_voltage_in;
	logic        main_power_relay, servo_on, quick_halt_decel, alarm_clear;
	int          n_errors, comparisons, i;
	logic [15:0] rd;
	dsm_drive_fsm #(.FR_HOLD_CYC(50), .QS_CODE(2)) u_dut (.core_clk(core_clk), .rst_n(rst_n),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.alarm_in(alarm_in), .alarm_done_in(alarm_done_in), .quick_halt_done_in(quick_halt_done_in),
		.bus_voltage_in(bus_voltage_in), .main_power_relay(main_power_relay), .servo_on(servo_on),
		.quick_halt_decel(quick_halt_decel), .alarm_clear(alarm_clear));
	dsm_master_model u_master (.core_clk(core_clk), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
	////////////////////////////////////////////////////////////////////////
	// clock, 4 ns period
	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end
	// compare tasks
	task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_word
	task automatic chk_bit(input logic got, input logic exp);
		chk_word({15'h0000, got}, {15'h0000, exp});
	endtask : chk_bit
	// verdict and end of run
	task automatic report_and_stop();
		$display("comparisons=%0d n_errors=%0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : report_and_stop
	// command write, then let it act
	task automatic cmd(input logic [15:0] d);
		u_master.bus_wr(A_CMD, d, 4'h3);
		repeat (3) @(posedge core_clk);
	endtask : cmd
	// status read and masked compare
	task automatic st(input logic [15:0] exp, input logic [15:0] m);
		u_master.bus_rd(A_ST, rd);
		chk_word(rd & m, exp);
	endtask : st
	// walk up to operation enabled
	task automatic go_enabled();
		cmd(16'h0006);
		cmd(16'h0007);
		cmd(16'h000F);
		repeat (30) @(posedge core_clk);
	endtask : go_enabled
	////////////////////////////////////////////////////////////////////////
	task automatic t_init();
		st(16'h0000, 16'h004F);
		repeat (110) @(posedge core_clk);
		st(S_SOD, 16'h007F);
		$display("test init done");
	endtask : t_init
	task automatic t_regs();
		u_master.bus_wr(A_CMD, 16'h1234, 4'h3);
		u_master.bus_rd(A_CMD, rd);
		chk_word(rd, 16'h0234);
		u_master.bus_wr(A_CMD, 16'hAB55, 4'h1);
		u_master.bus_rd(A_CMD, rd);
		chk_word(rd, 16'h0255);
		u_master.bus_wr(A_CMD, 16'hFFFF, 4'h3);
		u_master.bus_rd(A_CMD, rd);
		chk_word(rd, 16'h83FF);
		cmd(16'h0000);
		u_master.bus_wr(A_ST, 16'h000F, 4'h3);
		st(S_SOD, 16'h007F);
		u_master.bus_rd(18'h00000, rd);
		chk_word(rd, 16'h0000);
		bus_voltage_in <= 1'b0;
		repeat (5) @(posedge core_clk);
		st(16'h0000, 16'h0010);
		bus_voltage_in <= 1'b1;
		repeat (5) @(posedge core_clk);
		$display("test regs done");
	endtask : t_regs
	task automatic t_power_path();
		cmd(16'h0006);
		st(S_RDY, 16'h007F);
		cmd(16'h0007);
		st(S_SWT, 16'h007F);
		chk_bit(main_power_relay, 1'b1);
		u_master.bus_wr(A_CMD, 16'h000F, 4'h3);
		for (i = 0; i < 50 && servo_on !== 1'b1; i++) @(posedge core_clk);
		chk_bit(servo_on, 1'b1);
		st(16'h0000, 16'h0004);
		repeat (30) @(posedge core_clk);
		st(S_ENA, 16'h007F);
		cmd(16'h0007);
		chk_bit(servo_on, 1'b0);
		st(S_SWT, 16'h007F);
		cmd(16'h0006);
		st(S_RDY, 16'h007F);
		chk_bit(main_power_relay, 1'b0);
		$display("test power path done");
	endtask : t_power_path
	task automatic t_off_paths();
		cmd(16'h0002);
		st(S_SOD, 16'h007F);
		cmd(16'h0006);
		cmd(16'h0007);
		cmd(16'h0000);
		st(S_SOD, 16'h007F);
		chk_bit(main_power_relay, 1'b0);
		go_enabled();
		cmd(16'h0006);
		st(S_RDY, 16'h007F);
		chk_word({main_power_relay, servo_on}, 16'h0000);
		go_enabled();
		cmd(16'h0000);
		st(S_SOD, 16'h007F);
		chk_bit(servo_on, 1'b0);
		cmd(16'h000F);
		st(S_SOD, 16'h007F);
		$display("test off paths done");
	endtask : t_off_paths
	task automatic t_qstop();
		go_enabled();
		cmd(16'h000B);
		chk_bit(quick_halt_decel, 1'b1);
		st(16'h0000, 16'h0028);
		cmd(16'h000F);
		st(16'h0000, 16'h0028);
		quick_halt_done_in <= 1'b1;
		repeat (8) @(posedge core_clk);
		st(S_SOD, 16'h007F);
		chk_word({quick_halt_decel, main_power_relay, servo_on}, 16'h0000);
		quick_halt_done_in <= 1'b0;
		go_enabled();
		cmd(16'h000B);
		cmd(16'h0000);
		st(S_SOD, 16'h007F);
		$display("test quick stop done");
	endtask : t_qstop
	task automatic t_fault();
		go_enabled();
		alarm_in <= 1'b1;
		repeat (6) @(posedge core_clk);
		alarm_in      <= 1'b0;
		alarm_done_in <= 1'b1;
		repeat (8) @(posedge core_clk);
		alarm_done_in <= 1'b0;
		st(16'h0008, 16'h004F);
		chk_word({main_power_relay, servo_on}, 16'h0000);
		cmd(16'h0080);
		repeat (10) @(posedge core_clk);
		cmd(16'h0000);
		st(16'h0008, 16'h004F);
		u_master.bus_wr(A_CMD, 16'h0080, 4'h3);
		for (i = 0; i < 200 && alarm_clear !== 1'b1; i++) @(posedge core_clk);
		chk_bit(alarm_clear, 1'b1);
		repeat (4) @(posedge core_clk);
		st(S_SOD, 16'h007F);
		cmd(16'h0000);
		alarm_in <= 1'b1;
		repeat (6) @(posedge core_clk);
		alarm_in      <= 1'b0;
		alarm_done_in <= 1'b1;
		repeat (8) @(posedge core_clk);
		st(16'h0008, 16'h004F);
		$display("test fault done");
	endtask : t_fault
	////////////////////////////////////////////////////////////////////////
	// watchdog against a hung handshake
	initial begin
		repeat (20000) @(posedge core_clk);
		n_errors++;
		report_and_stop();
	end
	// main sequence
	initial begin
		n_errors           = 0;
		comparisons        = 0;
		rst_n              = 1'b0;
		alarm_in           = 1'b0;
		alarm_done_in      = 1'b0;
		quick_halt_done_in = 1'b0;
		bus_voltage_in     = 1'b1;
		repeat (6) @(posedge core_clk);
		chk_word({avs_waitrequest, main_power_relay, servo_on, alarm_clear}, 16'h0008);
		rst_n <= 1'b1;
		t_init();
		t_regs();
		t_power_path();
		t_off_paths();
		t_qstop();
		t_fault();
		report_and_stop();
	end
endmodule : dsm_drive_fsm_tb
